// >>> pkg/mbg_cfg.svh
`ifndef MBG_CFG_SVH
`define MBG_CFG_SVH
// ----------------------------------------
// Bus geometry
// ----------------------------------------
`define MBG_DATA_W 36
`define MBG_ADDR_W 18
`define MBG_SEL_W 4
`define MBG_MAX_MODULES 16
// Module select granularity: 8192 words, so select bits sit above bit 12
`define MBG_GRAN_WORDS 8192
`define MBG_SEL_LSB 13
`define MBG_MEM_WORDS 8192
`define MBG_MEM_AW 13
// ----------------------------------------
// Timing
// ----------------------------------------
`define MBG_CLK_MHZ 50
`define MBG_TIMEOUT_US 100
`define MBG_TIMEOUT_CYC (`MBG_TIMEOUT_US * `MBG_CLK_MHZ)
`define MBG_CNT_W 16
`define MBG_MUX_CLR_CYC 2
`define MBG_CLR_CNT_W 2
`endif

// >>> pkg/mbg_pkg.sv
package mbg_pkg;
  `include "mbg_cfg.svh"
  typedef logic [`MBG_DATA_W-1:0] mbg_word_t;
  typedef logic [`MBG_ADDR_W-1:0] mbg_addr_t;
  typedef enum logic [1:0] {MBG_IDLE, MBG_REQ, MBG_XFER, MBG_WAIT} mbg_state_t;
  typedef enum logic [1:0] {MBG_M_IDLE, MBG_M_RD, MBG_M_WR} mbg_mstate_t;
endpackage

// >>> pkg/mbg_bus_if.sv
`timescale 1ns/100ps
interface mbg_bus_if;
  import mbg_pkg::*;
  // Processor side drives
  logic cycle_request;
  mbg_addr_t memory_address_line;
  logic rd_req;
  logic wr_req;
  mbg_word_t proc_data;
  logic proc_data_oe;
  logic proc_parity;
  logic proc_parity_oe;
  logic write_restart;
  logic mux_request;
  logic mux_clear_pulse;
  // Memory side drives
  mbg_word_t mem_data;
  logic mem_data_oe;
  logic mem_parity;
  logic mem_parity_oe;
  logic addr_ack;
  logic no_parity_stored;
  logic read_restart;
  logic mux_grant;
  // Resolved pulse lines: a pulse from either enabled transmitter
  mbg_word_t bus_data_line;
  logic bus_parity_line;
  assign bus_data_line = (proc_data_oe ? proc_data : '0) |
                         (mem_data_oe ? mem_data : '0);
  assign bus_parity_line = (proc_parity_oe & proc_parity) |
                           (mem_parity_oe & mem_parity);
  modport proc (
    output cycle_request, memory_address_line, rd_req, wr_req, proc_data,
    output proc_data_oe, proc_parity, proc_parity_oe, write_restart,
    output mux_request, mux_clear_pulse,
    input addr_ack, no_parity_stored, read_restart, mux_grant,
    input bus_data_line, bus_parity_line
  );
  modport mem (
    output mem_data, mem_data_oe, mem_parity, mem_parity_oe, addr_ack,
    output no_parity_stored, read_restart, mux_grant,
    input cycle_request, memory_address_line, rd_req, wr_req,
    input write_restart, mux_request, mux_clear_pulse,
    input bus_data_line, bus_parity_line
  );
endinterface

// >>> verilog/mbg_timeout.sv
`timescale 1ns/100ps
`include "mbg_cfg.svh"
// Shared 100 us watchdog: runs while armed, clears on any stop.
module mbg_timeout
  import mbg_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `MBG_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Control
  input wire logic run,
  input wire logic stop,
  // Result
  output logic expired
);
  logic [`MBG_CNT_W-1:0] count;
  logic [`MBG_CNT_W-1:0] next_count;
  wire at_limit = (count == `MBG_CNT_W'(TIMEOUT_CYC - 1));

  // Count only while armed; stop wins so a late ack is never a timeout
  assign next_count = (stop || !run || at_limit) ? '0 : count + 1'b1;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      count <= '0;
      expired <= 1'b0;
    end else begin
      count <= next_count;
      expired <= run && !stop && at_limit;
    end
  end
endmodule // mbg_timeout

// >>> verilog/mbg_proc_end.sv
`timescale 1ns/100ps
`include "mbg_cfg.svh"
// ----------------------------------------
// Overview of operation
// ----------------------------------------
// Overview of operation
// - Data one is pulse, zero none
// - Receiver clears capture register before pulses
// - Processor sends odd parity on parity line
// - Memory stores parity, returns on reads
// - Only active memory enables receivers
// - Processor receivers off while transmitting
// - Hold mux request while access wanted
// - All drivers off without mux grant; mux clear is gated only by power_fail, not by grant
// - After grant, run cycles as direct
// - Direct wiring holds grant asserted
// - Mux clear on hang or nonexistent
// - 100 us without ack: nonexistent, trap
// - Memory restarts stalled request after 100us
// - Cycle request false across power changes
// - Address outputs inactive before power falls
// - No pulses during power transitions
// - One master, at most 16 modules
// - Module size up to 262144, 8K steps
// - Ack clears cycle request immediately
// - Read restart with data; write restart after
module mbg_proc_end
  import mbg_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `MBG_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Power transition gate, high while supplies are not good
  input wire logic power_fail,
  // User command
  input wire logic start,
  input wire logic do_read,
  input wire logic do_write,
  input wire mbg_addr_t addr,
  input wire mbg_word_t wdata,
  // User result
  output logic done,
  output mbg_word_t rdata,
  output logic parity_error,
  output logic nxm,
  output logic busy,
  // Bus
  mbg_bus_if.proc bus
);
  mbg_state_t state;
  mbg_state_t next_state;
  logic req;
  mbg_addr_t addr_q;
  logic rd_q;
  logic wr_q;
  mbg_word_t wdata_q;
  mbg_word_t cap;
  logic cap_par;
  logic ign_par;
  logic acked;
  logic wr_sent;
  logic expired;
  logic [`MBG_CLR_CNT_W-1:0] clr_cnt;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire granted = bus.mux_grant && !power_fail;
  wire take = (state == MBG_IDLE) && start && (do_read || do_write);
  wire ack_now = bus.addr_ack && (state == MBG_REQ);
  // A late ack in the expiry cycle wins over the timeout
  wire nxm_now = (state == MBG_REQ) && expired && !ack_now;
  wire rd_end = rd_q && bus.read_restart;
  wire send_wr = (state == MBG_XFER) && wr_q && !wr_sent && (!rd_q || acked);
  wire finish = (state == MBG_XFER) && (wr_q ? wr_sent : rd_end);
  wire odd_par = ~^wdata_q;
  wire rx_par_ok = ign_par || ((^cap ^ cap_par) == 1'b1);

  // Next state
  always_comb begin
    next_state = state;
    unique case (state)
      MBG_IDLE: if (take) next_state = MBG_REQ;
      MBG_REQ: begin
        if (ack_now) next_state = MBG_XFER;
        else if (expired) next_state = MBG_IDLE;
      end
      MBG_XFER: if (finish) next_state = MBG_WAIT;
      MBG_WAIT: next_state = MBG_IDLE;
    endcase
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Request flop falls on the ack edge itself to avoid a second cycle
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state <= MBG_IDLE;
      req <= 1'b0;
      addr_q <= '0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      wdata_q <= '0;
      acked <= 1'b0;
      wr_sent <= 1'b0;
    end else begin
      state <= next_state;
      req <= (next_state == MBG_REQ) && granted && !ack_now;
      acked <= (state == MBG_XFER);
      wr_sent <= (state == MBG_XFER) && (wr_sent || send_wr);
      if (take) begin
        addr_q <= addr;
        rd_q <= do_read;
        wr_q <= do_write;
        wdata_q <= wdata;
      end
    end
  end

  // Capture register: pulses only set bits, so clear at cycle start
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cap <= '0;
      cap_par <= 1'b0;
      ign_par <= 1'b0;
    end else if (take) begin
      cap <= '0;
      cap_par <= 1'b0;
      ign_par <= 1'b0;
    end else if (state == MBG_XFER && rd_q && !send_wr && !wr_sent) begin
      cap <= cap | bus.bus_data_line;
      cap_par <= cap_par | bus.bus_parity_line;
    end else if (ack_now) begin
      ign_par <= bus.no_parity_stored;
    end
  end

  // ----------------------------------------
  // Bus drivers
  // ----------------------------------------
  // Address lines parked at zero in MBG_IDLE and during power loss
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      bus.cycle_request <= 1'b0;
      bus.memory_address_line <= '0;
      bus.rd_req <= 1'b0;
      bus.wr_req <= 1'b0;
      bus.proc_data <= '0;
      bus.proc_data_oe <= 1'b0;
      bus.proc_parity <= 1'b0;
      bus.proc_parity_oe <= 1'b0;
      bus.write_restart <= 1'b0;
      bus.mux_request <= 1'b0;
    end else begin
      bus.cycle_request <= req && granted && !ack_now;
      bus.memory_address_line <= (granted && state != MBG_IDLE) ?
                                 addr_q : '0;
      bus.rd_req <= granted && state == MBG_REQ && rd_q;
      bus.wr_req <= granted && state == MBG_REQ && wr_q;
      bus.proc_data <= send_wr ? wdata_q : '0;
      bus.proc_data_oe <= send_wr && granted;
      bus.proc_parity <= send_wr && odd_par;
      bus.proc_parity_oe <= send_wr && granted;
      bus.write_restart <= wr_sent && !bus.write_restart &&
                           !acked_wr_done() && granted;
      bus.mux_request <= (state != MBG_IDLE || take) && !power_fail;
    end
  end

  function automatic logic acked_wr_done();
    return (state != MBG_XFER);
  endfunction

  // ----------------------------------------
  // Nonexistent memory watchdog and mux clear
  // ----------------------------------------
  mbg_timeout #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_nxm (
    .clock(clock),
    .rst_b(rst_b),
    .run(state == MBG_REQ),
    .stop(ack_now),
    .expired(expired)
  );

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      clr_cnt <= '0;
      bus.mux_clear_pulse <= 1'b0;
    end else begin
      if (nxm_now) clr_cnt <= `MBG_CLR_CNT_W'(`MBG_MUX_CLR_CYC);
      else if (clr_cnt != '0) clr_cnt <= clr_cnt - 1'b1;
      bus.mux_clear_pulse <= (clr_cnt != '0) && !power_fail;
    end
  end

  // ----------------------------------------
  // User result
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      done <= 1'b0;
      rdata <= '0;
      parity_error <= 1'b0;
      nxm <= 1'b0;
      busy <= 1'b0;
    end else begin
      done <= (state == MBG_WAIT) || nxm_now;
      nxm <= nxm_now;
      parity_error <= (state == MBG_WAIT) && rd_q && !rx_par_ok;
      if (state == MBG_WAIT && rd_q) rdata <= cap;
      busy <= (next_state != MBG_IDLE);
    end
  end
endmodule // mbg_proc_end

// >>> verilog/mbg_mem_end.sv
`timescale 1ns/100ps
`include "mbg_cfg.svh"
// Memory module end: one 8K-word module, selected by address bits above 12.
module mbg_mem_end
  import mbg_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `MBG_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Power and maintenance
  input wire logic power_fail,
  input wire logic recover_en,
  input wire logic [`MBG_SEL_W-1:0] module_select,
  // Status
  output logic restarted,
  // Bus
  mbg_bus_if.mem bus
);
  mbg_mstate_t state;
  logic [`MBG_DATA_W:0] mem [`MBG_MEM_WORDS];
  logic [`MBG_MEM_AW-1:0] ma;
  logic wr_q;
  mbg_word_t cap;
  logic cap_par;
  logic stall;
  logic rd_phase;

  // Selection over up to 16 modules at 8K granularity
  wire sel_hit = bus.memory_address_line[`MBG_SEL_LSB +: `MBG_SEL_W] ==
                 module_select;
  wire accept = (state == MBG_M_IDLE) && bus.cycle_request && sel_hit &&
                !power_fail && (bus.rd_req || bus.wr_req);
  wire active = (state != MBG_M_IDLE);
  wire rx_on = (state == MBG_M_WR);
  wire abort = stall && recover_en;

  // Faulty request watchdog
  mbg_timeout #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_stall (
    .clock(clock),
    .rst_b(rst_b),
    .run(active),
    .stop(!active),
    .expired(stall)
  );

  // Cycle sequencer; read of a read-modify-write runs before its write
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state <= MBG_M_IDLE;
      ma <= '0;
      wr_q <= 1'b0;
      rd_phase <= 1'b0;
    end else if (abort) begin
      state <= MBG_M_IDLE;
    end else begin
      unique case (state)
        MBG_M_IDLE: if (accept) begin
          ma <= bus.memory_address_line[`MBG_MEM_AW-1:0];
          wr_q <= bus.wr_req;
          rd_phase <= 1'b0;
          state <= bus.rd_req ? MBG_M_RD : MBG_M_WR;
        end
        MBG_M_RD: if (rd_phase) state <= wr_q ? MBG_M_WR : MBG_M_IDLE;
          else rd_phase <= 1'b1;
        MBG_M_WR: if (bus.write_restart) state <= MBG_M_IDLE;
        default: state <= MBG_M_IDLE;
      endcase
    end
  end

  // Capture and store incoming word with its parity bit
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cap <= '0;
      cap_par <= 1'b0;
    end else if (accept) begin
      cap <= '0;
      cap_par <= 1'b0;
    end else if (rx_on) begin
      cap <= cap | bus.bus_data_line;
      cap_par <= cap_par | bus.bus_parity_line;
    end
  end

  always_ff @(posedge clock) begin
    if (rx_on && bus.write_restart && !abort) begin
      mem[ma] <= {cap_par | bus.bus_parity_line,
                  cap | bus.bus_data_line};
    end
  end

  // Pulse transmitters, gated off during power transitions
  wire send_rd = (state == MBG_M_RD) && !rd_phase && !power_fail;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      bus.addr_ack <= 1'b0;
      bus.no_parity_stored <= 1'b0;
      bus.mem_data <= '0;
      bus.mem_data_oe <= 1'b0;
      bus.mem_parity <= 1'b0;
      bus.mem_parity_oe <= 1'b0;
      bus.read_restart <= 1'b0;
      bus.mux_grant <= 1'b0;
      restarted <= 1'b0;
    end else begin
      bus.addr_ack <= accept;
      bus.no_parity_stored <= 1'b0;
      bus.mem_data <= send_rd ? mem[ma][`MBG_DATA_W-1:0] : '0;
      bus.mem_data_oe <= send_rd;
      bus.mem_parity <= send_rd && mem[ma][`MBG_DATA_W];
      bus.mem_parity_oe <= send_rd;
      bus.read_restart <= send_rd;
      bus.mux_grant <= 1'b1;
      restarted <= abort;
    end
  end
endmodule // mbg_mem_end

// >>> testbench/mbg_bus_assertions.sv
`timescale 1ns/100ps
`include "mbg_cfg.svh"
// ----------------------------------------
// Bus checker
// ----------------------------------------
module mbg_bus_assertions
  import mbg_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `MBG_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Bus
  input wire logic cycle_request,
  input wire logic rd_req,
  input wire logic addr_ack,
  input wire logic proc_data_oe,
  input wire logic mem_data_oe,
  input wire logic read_restart,
  input wire logic mux_request,
  input wire logic mux_grant,
  input wire logic mux_clear_pulse,
  input wire logic no_parity_stored
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // Request age; bounded so a lost ack cannot hang the bus
  logic [15:0] wait_cnt;
  always_ff @(posedge clock) begin
    if (!rst_b || !cycle_request || addr_ack) begin
      wait_cnt <= '0;
    end else begin
      wait_cnt <= wait_cnt + 16'h1;
    end
  end
  sequence s_rd_ack;
    addr_ack && $past(rd_req);
  endsequence
  sequence s_clr_start;
    $rose(mux_clear_pulse);
  endsequence
  a_ack_drops_req: assert property (addr_ack |=> !cycle_request)
    else $error("cycle request held after acknowledge");
  a_ack_after_req: assert property (addr_ack |-> $past(cycle_request))
    else $error("acknowledge without request");
  a_one_driver: assert property (!(proc_data_oe && mem_data_oe))
    else $error("both ends drive data");
  a_grant_held: assert property ($past(rst_b) |-> mux_grant)
    else $error("grant dropped");
  a_drive_granted: assert property (
    (cycle_request || proc_data_oe || mux_clear_pulse) |-> mux_grant)
    else $error("driver active without grant");
  a_req_held: assert property (cycle_request |-> mux_request)
    else $error("mux request not held");
  a_read_restart: assert property (s_rd_ack |=> read_restart)
    else $error("read restart late");
  a_clear_two: assert property (
    s_clr_start |-> mux_clear_pulse [*2] ##1 !mux_clear_pulse)
    else $error("mux clear width wrong");
  a_parity_kept: assert property (!no_parity_stored)
    else $error("parity not stored");
  a_nxm_bound: assert property (
    wait_cnt <= 16'(TIMEOUT_CYC + 4))
    else $error("request outlived timeout");
endmodule // mbg_bus_assertions

// >>> testbench/memory_bus_data_and_mux_grant_tb_top.sv
`timescale 1ns/100ps
// ----------------------------------------
// Bench: processor end facing memory end
// ----------------------------------------
module memory_bus_data_and_mux_grant_tb_top;
  import mbg_pkg::*;
  localparam int unsigned TCYC = 20;
  localparam logic [3:0] SEL = 4'h3;
  logic clock, rst_b, power_fail, start, do_read, do_write, bad;
  logic done, parity_error, nxm, busy, restarted, restarted_2, cap_p;
  logic recover_en_2;
  mbg_addr_t addr, a;
  mbg_word_t wdata, rdata, exp_w, cap_d, d;
  int err_count, n_compared, seed, cyc, n;
  mbg_word_t model [mbg_addr_t];
  mbg_addr_t alist [$];
  mbg_bus_if bus ();
  mbg_bus_if bus_2 ();
  mbg_proc_end #(.TIMEOUT_CYC(TCYC)) i_mbg_proc_end (
    .clock(clock), .rst_b(rst_b), .power_fail(power_fail), .start(start),
    .do_read(do_read), .do_write(do_write), .addr(addr), .wdata(wdata),
    .done(done), .rdata(rdata), .parity_error(parity_error), .nxm(nxm),
    .busy(busy), .bus(bus.proc));
  mbg_mem_end #(.TIMEOUT_CYC(TCYC)) i_mbg_mem_end (
    .clock(clock), .rst_b(rst_b), .power_fail(power_fail),
    .recover_en(1'b1), .module_select(SEL), .restarted(restarted),
    .bus(bus.mem));
  // Second memory end, fed by a requester that never restarts
  mbg_mem_end #(.TIMEOUT_CYC(TCYC)) i_mbg_mem_end_2 (
    .clock(clock), .rst_b(rst_b), .power_fail(1'b0),
    .recover_en(recover_en_2), .module_select(SEL),
    .restarted(restarted_2), .bus(bus_2.mem));
  mbg_bus_assertions #(.TIMEOUT_CYC(TCYC)) i_mbg_bus_assertions (
    .clock(clock), .rst_b(rst_b), .cycle_request(bus.cycle_request),
    .rd_req(bus.rd_req), .addr_ack(bus.addr_ack),
    .proc_data_oe(bus.proc_data_oe), .mem_data_oe(bus.mem_data_oe),
    .read_restart(bus.read_restart), .mux_request(bus.mux_request),
    .mux_grant(bus.mux_grant), .mux_clear_pulse(bus.mux_clear_pulse),
    .no_parity_stored(bus.no_parity_stored));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("Error %0t: %s", $time, msg);
    end
  endtask
  task end_of_test;
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Hang guard; the whole run needs a few hundred cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("Error %0t: run timed out", $time);
      end_of_test;
    end
  end
  // Wire watch: data and parity pulses as seen on the lines
  always @(posedge clock) begin
    if (bus.proc_data_oe === 1'b1) cap_d = bus.bus_data_line;
    if (bus.proc_parity_oe === 1'b1) cap_p = bus.bus_parity_line;
    if (bus.write_restart === 1'b1) begin
      chk(cap_d === exp_w, "write data on wire");
      chk((^{cap_d, cap_p}) === 1'b1, "parity on wire");
    end
    if (rst_b === 1'b1 && restarted !== 1'b0) begin
      chk(1'b0, "stray restart");
    end
  end
  // One user command, waited on with a bound
  task automatic op(input logic rd, input logic wr, input mbg_addr_t ad,
                    input mbg_word_t dw);
    bit got;
    @(negedge clock);
    start = 1'b1;
    do_read = rd;
    do_write = wr;
    addr = ad;
    wdata = dw;
    exp_w = dw;
    @(negedge clock);
    start = 1'b0;
    chk(busy === 1'b1, "not busy after start");
    got = 1'b0;
    for (int i = 0; i < 200 && !got; i++) begin
      @(posedge clock);
      #1;
      got = (done === 1'b1) || (nxm === 1'b1);
    end
    chk(got, "no completion");
    chk(busy === 1'b0, "busy after completion");
  endtask
  task automatic wait_rs(input int lim);
    n = 0;
    while (n < lim && restarted_2 !== 1'b1) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask
  // Faulty write on the second end: ack taken, no write restart
  task automatic stall();
    @(negedge clock);
    bus_2.memory_address_line = {1'b0, SEL, 13'h5};
    bus_2.wr_req = 1'b1;
    bus_2.cycle_request = 1'b1;
    for (int i = 0; i < 20 && bus_2.addr_ack !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    @(negedge clock);
    bus_2.cycle_request = 1'b0;
  endtask
  initial begin
    seed = 32'h596fbd20;
    err_count = 0;
    n_compared = 0;
    cyc = 0;
    {rst_b, power_fail, start, do_read, do_write, recover_en_2} = '0;
    addr = '0;
    wdata = '0;
    exp_w = '0;
    bus_2.cycle_request = 1'b0;
    bus_2.memory_address_line = '0;
    bus_2.rd_req = 1'b0;
    bus_2.wr_req = 1'b0;
    bus_2.write_restart = 1'b0;
    bus_2.proc_data_oe = 1'b0;
    bus_2.proc_data = '0;
    bus_2.proc_parity = 1'b0;
    bus_2.proc_parity_oe = 1'b0;
    bus_2.mux_request = 1'b0;
    bus_2.mux_clear_pulse = 1'b0;
    repeat (20) @(negedge clock);
    rst_b = 1'b1;
    repeat (2) @(negedge clock);
    // Seed words, then reads, writes and read-modify-writes in turn
    for (int k = 0; k < 18; k++) begin
      a = (k < 6) ? {1'b0, SEL, 13'($random(seed))} : alist[k % 6];
      d = mbg_word_t'({$random(seed), $random(seed)});
      if (k < 6) alist.push_back(a);
      op(k < 6 ? 1'b0 : (k % 3 != 1), k < 6 || (k % 3 != 0), a, d);
      if (k >= 6 && k % 3 != 1) begin
        chk(rdata === model[a], "read data");
        chk(parity_error === 1'b0, "parity flagged");
      end
      if (k < 6 || k % 3 != 0) model[a] = d;
    end
    // Absent module: timeout, clear, then a good cycle again
    op(1'b1, 1'b0, {1'b0, SEL + 4'h1, 13'h0}, '0);
    chk(nxm === 1'b1, "no timeout");
    op(1'b1, 1'b0, alist[0], '0);
    chk(rdata === model[alist[0]], "read after clear");
    // Supplies bad: nothing may move on the bus
    @(negedge clock);
    power_fail = 1'b1;
    start = 1'b1;
    bad = 1'b0;
    @(negedge clock);
    start = 1'b0;
    repeat (40) begin
      @(posedge clock);
      bad |= bus.cycle_request | bus.proc_data_oe | bus.mem_data_oe |
             (bus.memory_address_line != '0) | bus.mux_clear_pulse;
    end
    chk(bad === 1'b0, "bus active in power change");
    @(negedge clock);
    rst_b = 1'b0;
    repeat (20) @(negedge clock);
    power_fail = 1'b0;
    rst_b = 1'b1;
    repeat (2) @(negedge clock);
    op(1'b0, 1'b1, alist[1], 36'h5a5a5a5a5);
    op(1'b1, 1'b0, alist[1], '0);
    chk(rdata === 36'h5a5a5a5a5, "read after reset");
    // Stall recovery: off by switch, then on
    stall();
    wait_rs(3 * TCYC);
    chk(restarted_2 !== 1'b1, "restart while disabled");
    @(negedge clock);
    recover_en_2 = 1'b1;
    wait_rs(TCYC + 10);
    chk(restarted_2 === 1'b1, "no restart");
    stall();
    wait_rs(TCYC + 10);
    chk(restarted_2 === 1'b1 && n >= TCYC - 4, "restart time");
    end_of_test;
  end
endmodule // memory_bus_data_and_mux_grant_tb_top
